// *** hw/rsq_pkg.sv ***
// rsq_pkg.sv - constants for the reset sequencer and mirror control pins
package rsq_pkg;
    localparam int unsigned CLK_FREQ_HZ      = 100_000_000;
    localparam int unsigned DELAY_TIME_NS    = 5_000;
    localparam int unsigned MIN_WIDTH_TIME_US = 2_000;
    // longest time rounds down, least time also rounds down to whole MHz
    localparam int unsigned DELAY_CYCLES     = (DELAY_TIME_NS * (CLK_FREQ_HZ / 1_000_000)) / 1_000;
    localparam int unsigned MIN_WIDTH_CYCLES = MIN_WIDTH_TIME_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int unsigned NUM_RESETS       = 3;
    localparam int unsigned IDX_GENERAL      = 0;
    localparam int unsigned IDX_CONTROLLER   = 1;
    localparam int unsigned IDX_FRONTEND     = 2;
    localparam int unsigned ADDR_W           = 4;
    localparam int unsigned MODE_W           = 2;
    localparam int unsigned SEL_W            = 2;
    localparam logic        RESET_ACTIVE_N   = 1'b0;
    localparam logic        OE_RESET_N       = 1'b1;
    typedef enum logic [2:0] {
        RSQ_HOLD  = 3'b001,
        RSQ_DELAY = 3'b010,
        RSQ_RUN   = 3'b100
    } rsq_state_e;
endpackage

// *** hw/rsq_reset_sequencer.sv ***
// rsq_reset_sequencer.sv - reset outputs and mirror control pin group
`timescale 1ns/1ps

// Behaviour
// R1 - monitor raises power good only in range
// R2 - general reset low while power sense low
// R3 - general reset held until firmware release
// R4 - general reset asserts 5 us after event
// R5 - general reset lasts at least 2 ms
// R6 - controller reset low while power sense low
// R7 - controller reset held until firmware release
// R8 - optional controller reset 5 us after event
// R9 - controller reset lasts at least 2 ms
// R10 - frontend reset low while power sense low
// R11 - frontend reset held until software release
// R12 - frontend reset asserts 5 us after event
// R13 - frontend reset 2 ms after software release
// R14 - software control drives frontend reset directly
// R15 - frontend interrupt active high, idle low
// R16 - output enable active low, primary only
// R17 - primary drives 4-bit mirror address
// R18 - primary drives 2-bit mirror mode
// R19 - primary drives mirror select and strobe
// R20 - mirror interrupt input is active low
// R21 - monitor raises sense at 90 percent
// R22 - per-output release and minimum width counter
module rsq_reset_sequencer #(
    parameter int unsigned DELAY_CYC = rsq_pkg::DELAY_CYCLES,
    parameter int unsigned WIDTH_CYC = rsq_pkg::MIN_WIDTH_CYCLES
) (
    input  wire logic                        clock_i,
    input  wire logic                        rst_b_i,
    input  wire logic                        power_on_sense_i,
    input  wire logic                        power_good_in_i,
    input  wire logic                        internal_reset_req_i,
    input  wire logic                        general_release_i,
    input  wire logic                        controller_release_i,
    input  wire logic                        frontend_release_i,
    input  wire logic                        controller_event_en_i,
    input  wire logic                        frontend_force_i,
    input  wire logic                        frontend_irq_in_i,
    input  wire logic                        mirror_irq_in_n_i,
    input  wire logic                        secondary_i,
    input  wire logic                        mirror_oe_req_i,
    input  wire logic [rsq_pkg::ADDR_W-1:0]  mirror_address_req_i,
    input  wire logic [rsq_pkg::MODE_W-1:0]  mirror_mode_req_i,
    input  wire logic [rsq_pkg::SEL_W-1:0]   mirror_select_req_i,
    input  wire logic                        mirror_strobe_req_i,
    output logic                             general_reset_out_n_o,
    output logic                             controller_reset_out_n_o,
    output logic                             frontend_reset_out_n_o,
    output logic                             frontend_irq_o,
    output logic                             mirror_irq_o,
    output logic                             mirror_output_enable_n_o,
    output logic                             mirror_output_enable_oe_n_o,
    output logic [rsq_pkg::ADDR_W-1:0]       mirror_address_o,
    output logic [rsq_pkg::MODE_W-1:0]       mirror_mode_field_o,
    output logic [rsq_pkg::SEL_W-1:0]        mirror_select_field_o,
    output logic                             mirror_strobe_o,
    output logic                             mirror_group_oe_n_o
);
    import rsq_pkg::*;

    localparam int unsigned DCNT_W = (DELAY_CYC > 1) ? $clog2(DELAY_CYC + 1) : 1;
    localparam int unsigned WCNT_W = (WIDTH_CYC > 1) ? $clog2(WIDTH_CYC + 1) : 1;

    initial begin
        if (DELAY_CYC < 1 || WIDTH_CYC < 1) begin
            $error("delay and width counts must be at least one");
        end
    end

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    logic pg_d;
    logic ir_d;
    wire  pg_rise   = power_good_in_i & ~pg_d;
    wire  ir_rise   = internal_reset_req_i & ~ir_d;
    wire  event_det = pg_rise | ir_rise; // see R4 see R8 see R12

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pg_d <= 1'b0;
        end else begin
            pg_d <= power_good_in_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ir_d <= 1'b0;
        end else begin
            ir_d <= internal_reset_req_i;
        end
    end

    // ------------------------------------------------------------
    // per-output sequencers
    // ------------------------------------------------------------
    wire [NUM_RESETS-1:0] release_req;
    wire [NUM_RESETS-1:0] event_en;
    wire [NUM_RESETS-1:0] rst_n_vec;
    assign release_req[IDX_GENERAL]    = general_release_i;    // see R3
    assign release_req[IDX_CONTROLLER] = controller_release_i; // see R7
    assign release_req[IDX_FRONTEND]   = frontend_release_i;   // see R11
    assign event_en[IDX_GENERAL]       = 1'b1;
    assign event_en[IDX_CONTROLLER]    = controller_event_en_i; // see R8
    assign event_en[IDX_FRONTEND]      = 1'b1;

    genvar g;
    generate
        for (g = 0; g < NUM_RESETS; g++) begin : g_seq
            rsq_state_e        state;
            rsq_state_e        next_state;
            logic [DCNT_W-1:0] dcnt;
            logic [WCNT_W-1:0] wcnt;
            logic              rel_seen;
            logic              out_n;
            wire               width_done = (wcnt == '0);
            // frontend width counts from the software release
            wire               rel_now    = (g == IDX_FRONTEND) ? (release_req[g] | rel_seen) : release_req[g];
            wire               can_rel    = width_done & (rel_now | rel_seen); // see R22 see R5 see R9
            wire               delay_done = (dcnt == DCNT_W'(1));
            wire               sense_low  = ~power_on_sense_i;
            wire               fe_force   = (g == IDX_FRONTEND) & frontend_force_i; // see R14
            wire               load_delay = (state == RSQ_RUN) & (next_state == RSQ_DELAY);
            wire               enter_hold = (state == RSQ_DELAY) & (next_state == RSQ_HOLD);
            wire               leave_hold = (state == RSQ_HOLD) & (next_state == RSQ_RUN);
            // frontend counts only once released
            wire               count_down = (state == RSQ_HOLD) & ~width_done & ((g != IDX_FRONTEND) | rel_now);
            // output stays released through the event delay
            wire               next_out_n = ((next_state == RSQ_RUN) | (next_state == RSQ_DELAY)) & ~fe_force;

            always_comb begin
                next_state = state;
                case (state)
                    RSQ_HOLD:  next_state = can_rel ? RSQ_RUN : RSQ_HOLD;
                    RSQ_DELAY: next_state = delay_done ? RSQ_HOLD : RSQ_DELAY;
                    RSQ_RUN:   next_state = (event_det & event_en[g]) ? RSQ_DELAY : RSQ_RUN;
                    default:   next_state = RSQ_HOLD;
                endcase
            end

            always_ff @(posedge clock_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    state <= RSQ_HOLD;
                    out_n <= RESET_ACTIVE_N;
                end else if (sense_low) begin
                    state <= RSQ_HOLD; // see R2 see R6 see R10
                    out_n <= RESET_ACTIVE_N;
                end else begin
                    state <= next_state;
                    out_n <= next_out_n; // see R3 see R7 see R11 see R4 see R8 see R12
                end
            end

            always_ff @(posedge clock_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    dcnt <= '0;
                end else if (sense_low) begin
                    dcnt <= '0;
                end else if (load_delay) begin
                    dcnt <= DCNT_W'(DELAY_CYC);
                end else if (dcnt != '0) begin
                    dcnt <= dcnt - DCNT_W'(1);
                end
            end

            always_ff @(posedge clock_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    wcnt     <= WCNT_W'(WIDTH_CYC);
                    rel_seen <= 1'b0;
                end else if (sense_low || enter_hold) begin
                    wcnt     <= WCNT_W'(WIDTH_CYC);
                    rel_seen <= 1'b0;
                end else begin
                    if (leave_hold) begin
                        rel_seen <= 1'b0;
                    end else if (release_req[g]) begin
                        rel_seen <= 1'b1;
                    end
                    if (count_down) begin
                        wcnt <= wcnt - WCNT_W'(1); // see R13
                    end
                end
            end
            assign rst_n_vec[g] = out_n;
        end
    endgenerate

    // ------------------------------------------------------------
    // outputs and mirror control group
    // ------------------------------------------------------------
    wire              primary           = ~secondary_i;
    wire              next_general_n    = rst_n_vec[IDX_GENERAL] & power_on_sense_i;    // see R2
    wire              next_controller_n = rst_n_vec[IDX_CONTROLLER] & power_on_sense_i; // see R6
    wire              next_frontend_n   = rst_n_vec[IDX_FRONTEND] & power_on_sense_i;   // see R10
    wire              next_frontend_irq = frontend_irq_in_i;                             // see R15
    wire              next_mirror_irq   = ~mirror_irq_in_n_i;                            // see R20
    wire              next_oe_n         = ~(mirror_oe_req_i & primary);                  // see R16
    wire              next_oe_pin_n     = ~primary;                                      // see R16
    wire [ADDR_W-1:0] next_address      = primary ? mirror_address_req_i : '0;           // see R17
    wire [MODE_W-1:0] next_mode         = primary ? mirror_mode_req_i : '0;              // see R18
    wire [SEL_W-1:0]  next_select       = primary ? mirror_select_req_i : '0;            // see R19
    wire              next_strobe       = primary & mirror_strobe_req_i;                 // see R19
    wire              next_group_oe_n   = ~primary;                                      // see R17

    // ------------------------------------------------------------
    // output flops
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            general_reset_out_n_o <= RESET_ACTIVE_N;
        end else begin
            general_reset_out_n_o <= next_general_n;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            controller_reset_out_n_o <= RESET_ACTIVE_N;
        end else begin
            controller_reset_out_n_o <= next_controller_n;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frontend_reset_out_n_o <= RESET_ACTIVE_N;
        end else begin
            frontend_reset_out_n_o <= next_frontend_n;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frontend_irq_o <= 1'b0;
        end else begin
            frontend_irq_o <= next_frontend_irq;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mirror_irq_o <= 1'b0;
        end else begin
            mirror_irq_o <= next_mirror_irq;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mirror_output_enable_n_o <= OE_RESET_N;
        end else begin
            mirror_output_enable_n_o <= next_oe_n;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mirror_output_enable_oe_n_o <= 1'b1;
        end else begin
            mirror_output_enable_oe_n_o <= next_oe_pin_n;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mirror_address_o <= '0;
        end else begin
            mirror_address_o <= next_address;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mirror_mode_field_o <= '0;
        end else begin
            mirror_mode_field_o <= next_mode;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mirror_select_field_o <= '0;
        end else begin
            mirror_select_field_o <= next_select;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mirror_strobe_o <= 1'b0;
        end else begin
            mirror_strobe_o <= next_strobe;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mirror_group_oe_n_o <= 1'b1;
        end else begin
            mirror_group_oe_n_o <= next_group_oe_n;
        end
    end
endmodule

// *** tb/rsq_monitor.sv ***
// rsq_monitor.sv - voltage monitor model for power sense and power good
`timescale 1ns/1ps
module rsq_monitor (
    input  wire logic clock_i,
    input  wire logic supply_ok_i,
    input  wire logic glitch_i,
    output logic      power_on_sense_o,
    output logic      power_good_o
);
    always_ff @(posedge clock_i) begin
        power_on_sense_o <= supply_ok_i | power_good_o;
        power_good_o     <= supply_ok_i & power_on_sense_o & !glitch_i;
    end
endmodule

// *** tb/rsq_reset_sequencer_tb.sv ***
// rsq_reset_sequencer_tb.sv - scenario bench for the reset sequencer
`timescale 1ns/1ps
module rsq_reset_sequencer_tb;
    import rsq_pkg::*;
    localparam int unsigned DLY = 5;
    localparam int unsigned WID = 20;
    logic       clk = 0, rst_b = 0, sup = 0, glt = 0, ireq = 0, rel = 0, cen = 0, frc = 0, fiq = 0, miq_n = 1;
    logic       sec = 0, oe = 0, stb = 0, frel = 0, pos, pg, fio, mio, moe, moeoe, mst, goe;
    logic [3:0] adr = 4'h0, ma;
    logic [1:0] mode = 2'h0, sel = 2'h0, mm, ms;
    logic [2:0] rn;
    int         errors = 0, checks_done = 0, cyc = 0;
    rsq_monitor i_rsq_monitor (.clock_i(clk), .supply_ok_i(sup), .glitch_i(glt), .power_on_sense_o(pos), .power_good_o(pg));
    rsq_reset_sequencer #(.DELAY_CYC(DLY), .WIDTH_CYC(WID)) i_rsq_reset_sequencer (.clock_i(clk), .rst_b_i(rst_b),
        .power_on_sense_i(pos), .power_good_in_i(pg), .internal_reset_req_i(ireq), .general_release_i(rel),
        .controller_release_i(rel), .frontend_release_i(frel), .controller_event_en_i(cen), .frontend_force_i(frc),
        .frontend_irq_in_i(fiq), .mirror_irq_in_n_i(miq_n), .secondary_i(sec), .mirror_oe_req_i(oe),
        .mirror_address_req_i(adr), .mirror_mode_req_i(mode), .mirror_select_req_i(sel), .mirror_strobe_req_i(stb),
        .general_reset_out_n_o(rn[0]), .controller_reset_out_n_o(rn[1]), .frontend_reset_out_n_o(rn[2]),
        .frontend_irq_o(fio), .mirror_irq_o(mio), .mirror_output_enable_n_o(moe), .mirror_output_enable_oe_n_o(moeoe),
        .mirror_address_o(ma), .mirror_mode_field_o(mm), .mirror_select_field_o(ms), .mirror_strobe_o(mst),
        .mirror_group_oe_n_o(goe));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_rst(input logic [2:0] exp, input int lim);
        for (int i = 0; i < lim && rn !== exp; i++) step(1);
        chk("resets", {1'b0, exp}, {1'b0, rn});
    endtask
    task automatic t_power_up;
        sup = 1'b1;
        rel = 1'b1;
        frel = 1'b1;
        step(WID / 2);
        chk("early", 4'h0, {1'b0, rn});
        wait_rst(3'h7, WID + 8);
    endtask
    task automatic t_event;
        glt = 1'b1;
        step(1);
        glt = 1'b0;
        wait_rst(3'h2, DLY + 8);
        step(WID - 4);
        chk("held", 4'h2, {1'b0, rn});
        wait_rst(3'h7, WID);
        cen = 1'b1;
        ireq = 1'b1;
        step(1);
        ireq = 1'b0;
        wait_rst(3'h0, DLY + 8);
        wait_rst(3'h7, WID + 8);
        cen = 1'b0;
    endtask
    task automatic t_force;
        frc = 1'b1;
        wait_rst(3'h3, 4);
        frc = 1'b0;
        wait_rst(3'h7, WID + 8);
    endtask
    task automatic t_frontend;
        frel = 1'b0;
        ireq = 1'b1;
        step(1);
        ireq = 1'b0;
        wait_rst(3'h2, DLY + 8);
        wait_rst(3'h3, WID + 8);
        step(WID);
        chk("frontend held", 4'h3, {1'b0, rn});
        frel = 1'b1;
        step(WID - 2);
        chk("frontend width", 4'h3, {1'b0, rn});
        wait_rst(3'h7, 8);
    endtask
    task automatic t_sense;
        sup = 1'b0;
        rel = 1'b0;
        frel = 1'b0;
        wait_rst(3'h0, 6);
        step(3);
        chk("sense", 4'h0, {1'b0, rn});
        t_power_up();
    endtask
    task automatic t_mirror;
        {oe, adr, mode, sel, stb, fiq, miq_n} = {1'b1, 4'ha, 2'h2, 2'h1, 1'b1, 1'b1, 1'b0};
        step(2);
        chk("address", 4'ha, ma);
        chk("mode sel", 4'h9, {mm, ms});
        chk("enables", 4'h1, {moe, moeoe, goe, mst});
        chk("irqs", 4'h3, {2'h0, fio, mio});
        {sec, fiq, miq_n} = 3'h5;
        step(2);
        chk("address", 4'h0, ma);
        chk("mode sel", 4'h0, {mm, ms});
        chk("enables", 4'he, {moe, moeoe, goe, mst});
        chk("irqs", 4'h0, {2'h0, fio, mio});
        sec = 1'b0;
    endtask
    task automatic stop_test;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            stop_test();
        end
    end
    initial begin
        step(5);
        rst_b = 1'b1;
        t_power_up();
        t_mirror();
        t_event();
        t_force();
        t_frontend();
        t_sense();
        stop_test();
    end
endmodule

// *** tb/rsq_sva.sv ***
// rsq_sva.sv - port checker for the reset sequencer
`timescale 1ns/1ps
module rsq_sva import rsq_pkg::*; #(
    parameter int unsigned DELAY_CYC = 500,
    parameter int unsigned WIDTH_CYC = 200000
) (
    input wire logic              clock_i,
    input wire logic              rst_b_i,
    input wire logic              power_on_sense_i,
    input wire logic              power_good_in_i,
    input wire logic              internal_reset_req_i,
    input wire logic              controller_event_en_i,
    input wire logic              frontend_force_i,
    input wire logic              frontend_irq_in_i,
    input wire logic              secondary_i,
    input wire logic [ADDR_W-1:0] mirror_address_req_i,
    input wire logic              general_reset_out_n_o,
    input wire logic              controller_reset_out_n_o,
    input wire logic              frontend_reset_out_n_o,
    input wire logic              frontend_irq_o,
    input wire logic [ADDR_W-1:0] mirror_address_o,
    input wire logic              mirror_group_oe_n_o
);
    localparam int DLO = DELAY_CYC;
    localparam int DHI = DELAY_CYC + 6;
    wire  [2:0]  rn = {frontend_reset_out_n_o, controller_reset_out_n_o, general_reset_out_n_o};
    logic [31:0] gcnt;
    logic [31:0] ccnt;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // low-time counters for the width checks
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gcnt <= '0;
            ccnt <= '0;
        end else begin
            gcnt <= rn[0] ? '0 : gcnt + 32'h1;
            ccnt <= rn[1] ? '0 : ccnt + 32'h1;
        end
    end
    sense_low_a: assert property (!power_on_sense_i |=> rn == 3'h0)
        else $error("reset high while sense low");
    gen_width_a: assert property ($rose(rn[0]) |-> gcnt >= WIDTH_CYC)
        else $error("general reset too short");
    ctl_width_a: assert property ($rose(rn[1]) |-> ccnt >= WIDTH_CYC)
        else $error("controller reset too short");
    gen_event_a: assert property (($rose(power_good_in_i) || $rose(internal_reset_req_i)) && rn[0] && rn[2]
        |-> ##2 rn[0] ##[DLO:DHI] (rn & 3'h5) == 3'h0) else $error("event reset early or late");
    ctl_off_a: assert property (($rose(power_good_in_i) || $rose(internal_reset_req_i)) && !controller_event_en_i
        && rn[1] |-> rn[1] [*8]) else $error("controller reset while option off");
    ctl_on_a: assert property (($rose(power_good_in_i) || $rose(internal_reset_req_i)) && controller_event_en_i
        && rn[1] |-> ##2 rn[1] ##[DLO:DHI] !rn[1]) else $error("controller event reset early or late");
    force_low_a: assert property (frontend_force_i |-> ##[1:2] !rn[2])
        else $error("force did not drive reset");
    irq_copy_a: assert property (frontend_irq_o == $past(frontend_irq_in_i))
        else $error("frontend irq mismatch");
    second_off_a: assert property (secondary_i |=> mirror_group_oe_n_o && mirror_address_o == '0)
        else $error("secondary drives mirror group");
    primary_on_a: assert property (!secondary_i |=> !mirror_group_oe_n_o
        && mirror_address_o == $past(mirror_address_req_i)) else $error("primary address wrong");
endmodule
bind rsq_reset_sequencer rsq_sva #(.DELAY_CYC(DELAY_CYC), .WIDTH_CYC(WIDTH_CYC)) i_rsq_sva (
    .clock_i                  (clock_i),
    .rst_b_i                  (rst_b_i),
    .power_on_sense_i         (power_on_sense_i),
    .power_good_in_i          (power_good_in_i),
    .internal_reset_req_i     (internal_reset_req_i),
    .controller_event_en_i    (controller_event_en_i),
    .frontend_force_i         (frontend_force_i),
    .frontend_irq_in_i        (frontend_irq_in_i),
    .secondary_i              (secondary_i),
    .mirror_address_req_i     (mirror_address_req_i),
    .general_reset_out_n_o    (general_reset_out_n_o),
    .controller_reset_out_n_o (controller_reset_out_n_o),
    .frontend_reset_out_n_o   (frontend_reset_out_n_o),
    .frontend_irq_o           (frontend_irq_o),
    .mirror_address_o         (mirror_address_o),
    .mirror_group_oe_n_o      (mirror_group_oe_n_o)
);
